// [verilog/tkt_pkg.sv]
// Shared constants and carrier types for the transmitter keying timers.
package tkt_pkg;

    // Clock and time base
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
    localparam int S_PER_MIN = 60;
    localparam logic [9:0] SEC_PRESCALE_LOAD = 10'(MS_PER_S - 1);
    localparam logic [5:0] MIN_PRESCALE_LOAD = 6'(S_PER_MIN - 1);

    // Transmit and receive time-outs
    localparam logic [7:0] TX_LIMIT_DEFAULT_S = 8'h1E;
    localparam logic [7:0] TX_LIMIT_MIN_S = 8'h01;
    localparam logic [7:0] RX_LIMIT_MIN_M = 8'h01;

    // Output power in dBm
    localparam logic [5:0] POWER_MIN_DBM = 6'h14;
    localparam logic [5:0] POWER_MAX_DBM = 6'h25;
    localparam logic [5:0] POWER_DEFAULT_DBM = 6'h25;

    // Signal-to-noise reporting
    localparam int SNR_PERIOD_S = 2;
    localparam logic [1:0] SNR_PERIOD_LOAD = 2'(SNR_PERIOD_S - 1);
    localparam logic [7:0] SNR_MIN_DB = 8'h0A;
    localparam logic [7:0] SNR_MAX_DB = 8'h21;

    // Alarm codes and classes
    localparam int ALARM_COUNT = 32;
    localparam logic [4:0] ALARM_RX_TIMEOUT = 5'h0C;
    localparam logic [4:0] ALARM_TX_TIMEOUT = 5'h0D;
    localparam logic [31:0] ALARM_MAJOR_MASK = 32'h0000_FFFF;

    typedef struct packed {
        logic [7:0] key_delay_ms;
        logic [7:0] soft_dekey_delay;
        logic transmit_timeout_en;
        logic [7:0] transmit_timeout;
        logic receive_timeout_en;
        logic [7:0] receive_timeout_minutes;
    } tkt_cfg_type;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
        logic major;
        logic more;
    } tkt_alarm_type;

    typedef enum logic [2:0] {
        KS_IDLE,
        KS_KEY_WAIT,
        KS_KEYED,
        KS_DEKEY,
        KS_LOCKOUT
    } tkt_key_state_type;

endpackage

// [verilog/tkt_down_counter.sv]
// Loadable down counter that steps on a tick and stops at zero.
module tkt_down_counter #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_value_in,
    input wire logic tick_in,
    output logic [WIDTH-1:0] count_out,
    output logic zero_out
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("tkt_down_counter: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] count_reg;

    // Load wins over a tick in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= load_value_in;
        end else if (tick_in && count_reg != '0) begin
            count_reg <= count_reg - WIDTH'(1);
        end
    end

    assign count_out = count_reg;
    assign zero_out = (count_reg == '0);

endmodule

// [verilog/tkt_keying_timers.sv]
// Transmitter keying delays, time-outs, alarm reporting, power and SNR reporting.
//
// Overview of operation
// - Key request on push-to-talk or RTS keys transmitter after key-up delay.
// - After request drops, stay keyed for dekey delay; zero releases immediately.
// - Enabled transmit time-out unkeys transmitter after 1 to 255 keyed seconds.
// - After time-out unkey, ignore requests until the request line is dropped.
// - Transmit time-out has own enable; limit defaults to 30 seconds.
// - Raise alarm 12 when no received data within receive time-out.
// - Receive time-out counts 1 to 255 minutes; disable stops it firing.
// - Alarms report a code 00 to 31 with major or minor class.
// - Report several alarms one at a time, flag more, step on acknowledge.
// - While SNR monitoring, refresh value every 2 seconds, clamped 10 to 33 dB.
// - Output power accepts only 20 to 37 dBm, defaulting to 37 dBm.
// - RTS keys the transmitter regardless of data-keying setting.
// - Transmit time-out alarm 13 stays latched until transmitter next keys.
module tkt_keying_timers
    import tkt_pkg::*;
#(
    parameter int MS_TICK = MS_TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic push_to_talk_line_in,
    input wire logic rts_in,
    input wire logic rx_data_event_in,
    input wire tkt_cfg_type cfg_in,
    input wire logic [31:0] ext_alarm_in,
    input wire logic alarm_ack_in,
    input wire logic power_write_in,
    input wire logic [5:0] power_value_in,
    input wire logic snr_monitor_in,
    input wire logic [7:0] snr_measure_in,
    output logic tx_key_out,
    output logic timeout_lockout_out,
    output tkt_alarm_type alarm_report_out,
    output logic [5:0] output_power_setting_out,
    output logic power_reject_out,
    output logic [7:0] snr_value_out,
    output logic snr_update_out
);

    generate
        if (MS_TICK < 2 || MS_TICK > 32768) begin : g_bad_tick
            $error("tkt_keying_timers: MS_TICK out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] talk_sync_reg;
    logic [1:0] rts_sync_reg;
    logic key_req;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            talk_sync_reg <= 2'h0;
            rts_sync_reg <= 2'h0;
        end else begin
            talk_sync_reg <= {talk_sync_reg[0], push_to_talk_line_in};
            rts_sync_reg <= {rts_sync_reg[0], rts_in};
        end
    end
    assign key_req = talk_sync_reg[1] | rts_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // single millisecond base
    logic [14:0] ms_cnt_reg;
    logic ms_tick;
    logic sec_pre_zero;
    logic sec_tick;
    logic min_pre_zero;
    logic min_tick;
    logic armed_reg;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_reg <= 15'h0000;
        end else if (ms_tick) begin
            ms_cnt_reg <= 15'h0000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 15'h0001;
        end
    end
    assign ms_tick = (ms_cnt_reg == 15'(MS_TICK - 1));

    // full load once after reset, else the first second and minute come at once
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
        end
    end

    tkt_down_counter #(.WIDTH(10)) u_sec_pre (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in((ms_tick && sec_pre_zero) || !armed_reg), .load_value_in(SEC_PRESCALE_LOAD),
        .tick_in(ms_tick), .count_out(), .zero_out(sec_pre_zero)
    );
    assign sec_tick = ms_tick && sec_pre_zero;

    tkt_down_counter #(.WIDTH(6)) u_min_pre (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in((sec_tick && min_pre_zero) || !armed_reg), .load_value_in(MIN_PRESCALE_LOAD),
        .tick_in(sec_tick), .count_out(), .zero_out(min_pre_zero)
    );
    assign min_tick = sec_tick && min_pre_zero;

    ////////////////////////////////////////////////////////////////////////////
    tkt_key_state_type state_reg;
    tkt_key_state_type state_next;
    logic delay_load;
    logic [7:0] delay_value;
    logic delay_zero;
    logic txlim_load;
    logic [7:0] txlim_value;
    logic txlim_zero;
    logic txlim_expire;

    // a zero limit behaves as the least limit
    assign txlim_value = (cfg_in.transmit_timeout < TX_LIMIT_MIN_S) ? TX_LIMIT_MIN_S
                                                                    : cfg_in.transmit_timeout;
    // only with the separate enable set
    assign txlim_expire = cfg_in.transmit_timeout_en && txlim_zero;

    always_comb begin
        state_next = state_reg;
        delay_load = 1'b0;
        delay_value = cfg_in.key_delay_ms;
        txlim_load = 1'b0;
        unique case (state_reg)
            KS_IDLE: begin
                if (key_req) begin
                    delay_load = 1'b1;
                    txlim_load = 1'b1;
                    state_next = (cfg_in.key_delay_ms == 8'h00) ? KS_KEYED : KS_KEY_WAIT;
                end
            end
            KS_KEY_WAIT: begin
                txlim_load = 1'b1;
                if (!key_req) begin
                    state_next = KS_IDLE;
                end else if (delay_zero) begin
                    state_next = KS_KEYED;
                end
            end
            KS_KEYED: begin
                delay_value = cfg_in.soft_dekey_delay;
                if (txlim_expire) begin
                    state_next = KS_LOCKOUT;
                end else if (!key_req) begin
                    delay_load = 1'b1;
                    state_next = (cfg_in.soft_dekey_delay == 8'h00) ? KS_IDLE : KS_DEKEY;
                end
            end
            KS_DEKEY: begin
                if (txlim_expire) begin
                    state_next = KS_LOCKOUT;
                end else if (key_req) begin
                    state_next = KS_KEYED;
                end else if (delay_zero) begin
                    state_next = KS_IDLE;
                end
            end
            KS_LOCKOUT: begin
                // only a dropped request returns to unkeyed
                if (!key_req) begin
                    state_next = KS_IDLE;
                end
            end
            default: state_next = KS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= KS_IDLE;
            tx_key_out <= 1'b0;
            timeout_lockout_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            tx_key_out <= (state_next == KS_KEYED) || (state_next == KS_DEKEY);
            timeout_lockout_out <= (state_next == KS_LOCKOUT);
        end
    end

    tkt_down_counter #(.WIDTH(8)) u_delay (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in(delay_load), .load_value_in(delay_value),
        .tick_in(ms_tick), .count_out(), .zero_out(delay_zero)
    );

    // Counts keyed seconds only while keyed
    tkt_down_counter #(.WIDTH(8)) u_tx_limit (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in(txlim_load), .load_value_in(txlim_value),
        .tick_in(sec_tick && tx_key_out), .count_out(), .zero_out(txlim_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic rxlim_load;
    logic [7:0] rxlim_value;
    logic rxlim_zero;
    logic rx_alarm_set;
    logic rx_alarm_reg;
    logic tx_alarm_reg;
    logic tx_keys_now;

    // disabled timer stays loaded and never fires
    // also loads once after reset, so the first interval is a full one
    assign rxlim_load = rx_data_event_in || !cfg_in.receive_timeout_en || !armed_reg;
    assign rxlim_value = (cfg_in.receive_timeout_minutes < RX_LIMIT_MIN_M) ? RX_LIMIT_MIN_M
                                                           : cfg_in.receive_timeout_minutes;
    tkt_down_counter #(.WIDTH(8)) u_rx_limit (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in(rxlim_load), .load_value_in(rxlim_value),
        .tick_in(min_tick), .count_out(), .zero_out(rxlim_zero)
    );
    assign rx_alarm_set = rxlim_zero && !rxlim_load;

    // receive alarm, clear by new data wins over set
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_alarm_reg <= 1'b0;
        end else if (rx_alarm_set) begin
            rx_alarm_reg <= 1'b1;
        end else if (rx_data_event_in) begin
            rx_alarm_reg <= 1'b0;
        end
    end

    assign tx_keys_now = (state_reg == KS_IDLE || state_reg == KS_KEY_WAIT)
                         && state_next == KS_KEYED;
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_alarm_reg <= 1'b0;
        end else if (state_next == KS_LOCKOUT && state_reg != KS_LOCKOUT) begin
            tx_alarm_reg <= 1'b1;
        end else if (tx_keys_now) begin
            tx_alarm_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] active;
    logic [4:0] start_reg;
    logic found;
    logic [4:0] cur_code;

    always_comb begin
        active = ext_alarm_in;
        active[ALARM_RX_TIMEOUT] = rx_alarm_reg;
        active[ALARM_TX_TIMEOUT] = tx_alarm_reg;
    end

    // round-robin search from the code after the last acknowledged one
    always_comb begin
        logic [4:0] idx;
        idx = 5'h00;
        found = 1'b0;
        cur_code = 5'h00;
        for (int i = 0; i < ALARM_COUNT; i++) begin
            idx = start_reg + 5'(i);
            if (!found && active[idx]) begin
                found = 1'b1;
                cur_code = idx;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 5'h00;
        end else if (alarm_ack_in && found) begin
            start_reg <= cur_code + 5'h01;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            alarm_report_out <= '0;
        end else begin
            alarm_report_out.valid <= found;
            alarm_report_out.code <= cur_code;
            alarm_report_out.major <= found && ALARM_MAJOR_MASK[cur_code];
            alarm_report_out.more <= ($countones(active) > 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // out-of-range writes are refused and flagged
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            output_power_setting_out <= POWER_DEFAULT_DBM;
            power_reject_out <= 1'b0;
        end else begin
            power_reject_out <= 1'b0;
            if (power_write_in) begin
                if (power_value_in >= POWER_MIN_DBM && power_value_in <= POWER_MAX_DBM) begin
                    output_power_setting_out <= power_value_in;
                end else begin
                    power_reject_out <= 1'b1;
                end
            end
        end
    end

    logic snr_zero;
    logic snr_due;
    assign snr_due = snr_monitor_in && sec_tick && snr_zero;

    tkt_down_counter #(.WIDTH(2)) u_snr (
        .mclk_in(mclk_in), .rst_n_in(rst_n),
        .load_in(!snr_monitor_in || snr_due), .load_value_in(SNR_PERIOD_LOAD),
        .tick_in(sec_tick), .count_out(), .zero_out(snr_zero)
    );

    // periodic refresh, clamped to the reporting range
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            snr_value_out <= SNR_MIN_DB;
            snr_update_out <= 1'b0;
        end else begin
            snr_update_out <= snr_due;
            if (snr_due) begin
                snr_value_out <= (snr_measure_in < SNR_MIN_DB) ? SNR_MIN_DB :
                                 (snr_measure_in > SNR_MAX_DB) ? SNR_MAX_DB : snr_measure_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence s_keyed_expiring;
        state_reg == KS_KEYED && txlim_expire;
    endsequence
    sequence s_held_off;
        !tx_key_out && tx_alarm_reg;
    endsequence

    a_key_after_request: assert property ($rose(tx_key_out) |-> $past(key_req))
        else $error("transmitter keyed without a key request");
    a_dekey_zero_drop: assert property (state_reg == KS_KEYED && !txlim_expire && !key_req
        && cfg_in.soft_dekey_delay == 8'h00 |=> !tx_key_out)
        else $error("zero dekey delay did not release at once");
    a_timeout_force_unkey: assert property (s_keyed_expiring |=> s_held_off)
        else $error("transmit time-out did not unkey");
    a_lockout_ignores_key: assert property (state_reg == KS_LOCKOUT && key_req
        |=> !tx_key_out [*2])
        else $error("key request honoured during lockout");
    a_rx_timeout_alarm: assert property (rx_alarm_set |=> rx_alarm_reg && active[12])
        else $error("receive time-out alarm not raised");
    a_rx_disable_quiet: assert property (!cfg_in.receive_timeout_en && !rx_alarm_reg
        |=> !rx_alarm_reg)
        else $error("disabled receive time-out fired");
    a_alarm_more_flag: assert property (alarm_report_out.more
        |-> $past($countones(active)) > 1 && alarm_report_out.valid)
        else $error("more flag without several alarms");
    a_power_in_range: assert property (output_power_setting_out >= POWER_MIN_DBM
        && output_power_setting_out <= POWER_MAX_DBM)
        else $error("output power setting out of range");
    a_snr_in_range: assert property (snr_update_out |-> snr_value_out >= SNR_MIN_DB
        && snr_value_out <= SNR_MAX_DB && $past(snr_monitor_in))
        else $error("SNR report outside range or unrequested");
    a_tx_alarm_clears: assert property ($rose(tx_key_out) |-> !tx_alarm_reg)
        else $error("transmit time-out alarm survived rekey");

endmodule

// [bench/tkt_dte_model.sv]
// Data terminal model that drives the two key request lines.
module tkt_dte_model (
    input wire logic mclk_in,
    input wire logic timeout_lockout_in,
    output logic push_to_talk_line_out,
    output logic rts_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic saw_lockout;
    initial begin
        push_to_talk_line_out = 1'b0;
        rts_out = 1'b0;
        saw_lockout = 1'b0;
    end
    always @(posedge mclk_in) begin
        if (timeout_lockout_in === 1'b1) begin
            saw_lockout <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // either line keys
    task automatic key_on(input logic use_rts);
        if (saw_lockout) begin
            key_off();
            repeat (4) @(posedge mclk_in);
            saw_lockout = 1'b0;
        end
        @(posedge mclk_in);
        #1;
        push_to_talk_line_out = !use_rts;
        rts_out = use_rts;
    endtask
    task automatic key_off();
        @(posedge mclk_in);
        #1;
        push_to_talk_line_out = 1'b0;
        rts_out = 1'b0;
    endtask
endmodule

// [bench/tkt_keying_timers_tb_top.sv]
// Self-checking bench for keying delays, transmit time-out, alarms, power and SNR.
module tkt_keying_timers_tb_top
    import tkt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short millisecond keeps the seconds-scale tests affordable
    localparam int MS = 2;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic talk;
    logic rts;
    logic rx_ev = 1'b0;
    tkt_cfg_type cfg = '0;
    logic [31:0] ext_alarm = '0;
    logic ack = 1'b0;
    logic power_wr = 1'b0;
    logic [5:0] power_val = '0;
    logic snr_mon = 1'b0;
    logic [7:0] snr_meas = '0;
    logic tx_key_out;
    logic timeout_lockout_out;
    tkt_alarm_type alarm_report_out;
    logic [5:0] output_power_setting_out;
    logic power_reject_out;
    logic [7:0] snr_value_out;
    logic snr_update_out;
    logic [5:0] power_tab [6] = '{6'h13, 6'h14, 6'h25, 6'h26, 6'h3F, 6'h19};
    logic [7:0] snr_tab [3] = '{8'h05, 8'h30, 8'h14};
    logic [5:0] exp_power = 6'h25;
    logic [7:0] exp_snr;
    logic rej;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    tkt_keying_timers #(.MS_TICK(MS)) tkt_keying_timers_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .push_to_talk_line_in(talk), .rts_in(rts), .rx_data_event_in(rx_ev),
        .cfg_in(cfg), .ext_alarm_in(ext_alarm), .alarm_ack_in(ack),
        .power_write_in(power_wr), .power_value_in(power_val),
        .snr_monitor_in(snr_mon), .snr_measure_in(snr_meas),
        .tx_key_out(tx_key_out), .timeout_lockout_out(timeout_lockout_out),
        .alarm_report_out(alarm_report_out),
        .output_power_setting_out(output_power_setting_out),
        .power_reject_out(power_reject_out),
        .snr_value_out(snr_value_out), .snr_update_out(snr_update_out)
    );
    tkt_dte_model tkt_dte_model_i (
        .mclk_in(mclk_in), .timeout_lockout_in(timeout_lockout_out),
        .push_to_talk_line_out(talk), .rts_out(rts)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return tx_key_out;
            1: return timeout_lockout_out;
            default: return snr_update_out;
        endcase
    endfunction
    // Counts edges until the level shows; outside lo..hi is a mismatch
    task automatic wait_sig(input int s, input logic v, input int lo, input int hi,
            input string nm);
        int n;
        n = 0;
        while (sig(s) !== v && n <= hi) begin
            @(posedge mclk_in);
            #2;
            n++;
        end
        cmp_count++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("unexpected %s: cycles expected %0d..%0d, seen %0d", nm, lo, hi, n);
        end
    endtask
    task automatic hold_sig(input int s, input logic v, input int n, input string nm);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge mclk_in);
            #2;
            bad = bad | (sig(s) !== v);
        end
        chk(nm, 8'h00, {7'h00, bad});
    endtask
    task automatic ack_step();
        step();
        ack = 1'b1;
        step();
        ack = 1'b0;
        repeat (2) @(posedge mclk_in);
        #2;
    endtask
    task automatic key_cycle(input logic use_rts, input int d, input int s);
        step();
        cfg.key_delay_ms = 8'(d);
        cfg.soft_dekey_delay = 8'(s);
        tkt_dte_model_i.key_on(use_rts);
        wait_sig(0, 1'b1, (d == 0) ? 2 : (d - 1) * MS + 2, d * MS + 5, "key up");
        hold_sig(0, 1'b1, 20, "key held");
        tkt_dte_model_i.key_off();
        wait_sig(0, 1'b0, (s == 0) ? 2 : (s - 1) * MS + 2, s * MS + 6, "dekey");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cfg.transmit_timeout = TX_LIMIT_DEFAULT_S;
        cfg.receive_timeout_en = 1'b1;
        cfg.receive_timeout_minutes = 8'h01;
        repeat (12) @(posedge mclk_in);
        #1;
        reset_n_in = 1'b1;
        repeat (4) @(posedge mclk_in);
        #2;
        chk("tx_key", 8'h00, {7'h00, tx_key_out});
        chk("alarm", 8'h00, alarm_report_out);
        chk("power", 8'h25, {2'h0, output_power_setting_out});
        chk("snr", 8'h0A, snr_value_out);
        step();
        rx_ev = 1'b1;
        ext_alarm = 32'h0010_1008;
        step();
        rx_ev = 1'b0;
        repeat (4) @(posedge mclk_in);
        #2;
        // Bit 12 of the outside alarms is internal and must be skipped
        chk("alarm", {1'b1, 5'h03, 1'b1, 1'b1}, alarm_report_out);
        ack_step();
        chk("alarm", {1'b1, 5'h14, 1'b0, 1'b1}, alarm_report_out);
        ack_step();
        chk("alarm", {1'b1, 5'h03, 1'b1, 1'b1}, alarm_report_out);
        step();
        ext_alarm = '0;
        for (int i = 0; i < 6; i++) begin
            step();
            power_wr = 1'b1;
            power_val = power_tab[i];
            rej = power_val < 6'h14 || power_val > 6'h25;
            exp_power = rej ? exp_power : power_val;
            step();
            power_wr = 1'b0;
            #1;
            chk("power", {2'h0, exp_power}, {2'h0, output_power_setting_out});
            chk("reject", {7'h00, rej}, {7'h00, power_reject_out});
        end
        chk("alarm", 8'h00, alarm_report_out);
        key_cycle(1'b0, 10, 6);
        key_cycle(1'b1, 0, 0);
        key_cycle(1'b1, 3, 12);
        step();
        cfg.key_delay_ms = 8'd20;
        tkt_dte_model_i.key_on(1'b0);
        hold_sig(0, 1'b0, 10, "early drop");
        tkt_dte_model_i.key_off();
        hold_sig(0, 1'b0, 60, "cancelled key");
        step();
        cfg.key_delay_ms = 8'h00;
        cfg.soft_dekey_delay = 8'h00;
        cfg.transmit_timeout_en = 1'b1;
        cfg.transmit_timeout = 8'h01;
        tkt_dte_model_i.key_on(1'b0);
        wait_sig(0, 1'b1, 2, 6, "key up");
        wait_sig(0, 1'b0, 2, 1000 * MS + 8, "time-out");
        repeat (3) @(posedge mclk_in);
        #2;
        chk("lockout", 8'h01, {7'h00, timeout_lockout_out});
        chk("alarm", {1'b1, 5'h0D, 1'b1, 1'b0}, alarm_report_out);
        hold_sig(0, 1'b0, 100, "locked out");
        tkt_dte_model_i.key_off();
        wait_sig(1, 1'b0, 1, 8, "lockout end");
        step();
        cfg.transmit_timeout_en = 1'b0;
        tkt_dte_model_i.key_on(1'b1);
        wait_sig(0, 1'b1, 2, 12, "rekey");
        repeat (3) @(posedge mclk_in);
        #2;
        chk("alarm", 8'h00, alarm_report_out);
        hold_sig(0, 1'b1, 1300 * MS, "no time-out");
        tkt_dte_model_i.key_off();
        wait_sig(0, 1'b0, 1, 8, "dekey");
        step();
        cfg.receive_timeout_en = 1'b0;
        snr_mon = 1'b1;
        for (int i = 0; i < 3; i++) begin
            snr_meas = snr_tab[i];
            exp_snr = snr_meas < 8'h0A ? 8'h0A : (snr_meas > 8'h21 ? 8'h21 : snr_meas);
            wait_sig(2, 1'b1, (i == 0) ? 0 : 1996 * MS, 2004 * MS, "snr refresh");
            chk("snr", exp_snr, snr_value_out);
            @(posedge mclk_in);
            #2;
            chk("snr update", 8'h00, {7'h00, snr_update_out});
        end
        step();
        snr_mon = 1'b0;
        hold_sig(2, 1'b0, 2300 * MS, "snr stopped");
        stop_test();
    end
endmodule
